// File: bsp_defines.svh
/*
   offsets, field positions, write masks and reset values of the serial port
   clock-select and channel-select block.
   assumes a 16-bit register port addressed by word index.
*/
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

// register word indices
`define BSP_OFS_PIN_CTRL      6'h00
`define BSP_OFS_RATE_CFG_TWO  6'h01
`define BSP_OFS_RX_MC_CTRL    6'h02
`define BSP_OFS_TX_MC_CTRL    6'h03
`define BSP_OFS_RX_ENA_BASE   6'h10
`define BSP_OFS_TX_ENA_BASE   6'h18

// pin control fields
`define BSP_PIN_RSVD_MSB      15
`define BSP_PIN_TX_IO         13
`define BSP_PIN_RX_IO         12
`define BSP_PIN_TX_FS_DIR     11
`define BSP_PIN_RX_FS_DIR     10
`define BSP_PIN_TX_CLK_DIR    9
`define BSP_PIN_RX_CLK_DIR    8
`define BSP_PIN_SCLK_SEL      7
`define BSP_PIN_SCLK_STATE    6
`define BSP_PIN_TX_DATA_STATE 5
`define BSP_PIN_RX_DATA_STATE 4
`define BSP_PIN_WR_MASK       16'h3f8f

// rate generator config two fields
`define BSP_CFG2_CLK_MODE     13
`define BSP_CFG2_DIV_MSB      7
`define BSP_CFG2_WR_MASK      16'h20ff

// multichannel control fields
`define BSP_MC_WIDE           9
`define BSP_MC_UPPER_MSB      8
`define BSP_MC_UPPER_LSB      7
`define BSP_MC_LOWER_MSB      6
`define BSP_MC_LOWER_LSB      5
`define BSP_MC_CUR_MSB        4
`define BSP_MC_CUR_LSB        2
`define BSP_MC_SEL_MSB        1
`define BSP_MC_WR_MASK        16'h03e3

`define BSP_REG_RESET         16'h0000
`define BSP_CHAN_LAST         7'h7f

`endif

// File: bsp_pkg.sv
/*
   types shared by the serial port clock/channel-select block.
   assumes bsp_defines.svh for all numeric constants.
*/
package bsp_pkg;

   typedef enum logic [1:0] {
      BSP_SRC_EXT_SAMPLE,
      BSP_SRC_CPU,
      BSP_SRC_RX_PIN,
      BSP_SRC_TX_PIN
   } bsp_clk_src_t;

   // pin control register image
   typedef struct packed {
      logic [1:0] reserved;
      logic       tx_pins_as_io;
      logic       rx_pins_as_io;
      logic       tx_sync_direction;
      logic       rx_sync_direction;
      logic       tx_clock_direction;
      logic       rx_clock_direction;
      logic       sample_clock_pin_select;
      logic       sample_clock_pin_state;
      logic       tx_data_pin_state;
      logic       rx_data_pin_state;
      logic       tx_sync_polarity;
      logic       rx_sync_polarity;
      logic       tx_clock_polarity;
      logic       rx_clock_polarity;
   } bsp_pin_ctrl_t;

   // multichannel control, shared layout for rx and tx
   typedef struct packed {
      logic       wide_channel_mode;
      logic [1:0] upper_block_select;
      logic [1:0] lower_block_select;
      logic [1:0] multichannel_select;
   } bsp_mc_ctrl_t;

   typedef logic [7:0][15:0] bsp_enables_t;

endpackage

// File: bsp_sync2.sv
/*
   two-flop synchroniser for pin inputs.
   assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module bsp_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   // async in, synced out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // bsp_sync2
`default_nettype wire

// File: bsp_chan_gate.sv
/*
   channel-enable lookup for one direction of the multichannel stream.
   assumes the channel index counts words from frame start.
*/
`timescale 1ns/100ps
`default_nettype none
module bsp_chan_gate
   import bsp_pkg::*;
(
   // channel position
   input  wire logic [6:0]   chan_index,
   // configuration
   input  wire bsp_mc_ctrl_t mc_ctrl,
   input  wire bsp_enables_t enables,
   // result
   output logic              chan_on
);
   function automatic logic lookup(input logic [6:0] ch, input bsp_mc_ctrl_t mc,
                                   input bsp_enables_t ena);
      logic [2:0] blk;
      logic       hit;
      blk = ch[6:4];
      hit = 1'b0;
      if (mc.multichannel_select == 2'b00) begin
         hit = 1'b1;
      end else if (mc.wide_channel_mode) begin
         hit = ena[blk][ch[3:0]];
      end else if (blk == {mc.lower_block_select, 1'b0}) begin
         hit = ena[0][ch[3:0]];
      end else if (blk == {mc.upper_block_select, 1'b1}) begin
         hit = ena[1][ch[3:0]];
      end
      return hit;
   endfunction

   assign chan_on = lookup(chan_index, mc_ctrl, enables);
endmodule // bsp_chan_gate
`default_nettype wire

// File: bsp_clk_chan_sel.sv
/*
   serial port clock-source selection, rate generator and multichannel
   channel selection, with its register port.
   assumes a single-cycle register master on core_clk and pins
   asynchronous to core_clk; word and frame strobes come from the
   serial shifters on core_clk.
   pin clocks are found by sampling, so a pin clock must stay well
   below a quarter of core_clk.
*/
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "bsp_defines.svh"

// Behaviour
// - sample clock pin select at bit 7
// - generator clock mode at config bit 13
// - four-way generator input source selection
// - chosen clock pin loses its driver
// - rx-pin source clocks both sides, tx pin
// - pin control layout, reserved reads zero
// - frame is TDM stream, independent directions
// - narrow mode uses partitions A and B
// - wide mode uses partitions A to H
// - each partition spans sixteen consecutive channels
// - enable registers sixteen bits, reset zero
// - tx control wide bit 9, upper reserved
// - set bit passes channel, cleared suppresses
module bsp_clk_chan_sel
   import bsp_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [5:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [15:0] reg_rdata,
   // clock pins
   input  wire logic        rx_clock_pin_in,
   output logic             rx_clock_pin_out,
   output logic             rx_clock_pin_oe,
   input  wire logic        tx_clock_pin_in,
   output logic             tx_clock_pin_out,
   output logic             tx_clock_pin_oe,
   // frame sync pins
   input  wire logic        rx_sync_pin_in,
   output logic             rx_sync_pin_out,
   output logic             rx_sync_pin_oe,
   input  wire logic        tx_sync_pin_in,
   output logic             tx_sync_pin_out,
   output logic             tx_sync_pin_oe,
   // data pin states
   input  wire logic        rx_data_pin_in,
   input  wire logic        tx_data_pin_in,
   // internal frame sync from the shifters
   input  wire logic        rx_sync_gen,
   input  wire logic        tx_sync_gen,
   // bit clocks towards the shifters
   output logic             rx_bit_clk,
   output logic             tx_bit_clk,
   output logic             gen_clk,
   // channel stepping from the shifters
   input  wire logic        rx_frame_start,
   input  wire logic        rx_word_end,
   input  wire logic        tx_frame_start,
   input  wire logic        tx_word_end,
   // channel enables towards the shifters
   output logic             rx_chan_enabled,
   output logic             tx_chan_enabled
);
   bsp_pin_ctrl_t pin_q;
   logic          clk_mode_q;
   logic [7:0]    div_q;
   bsp_mc_ctrl_t  rx_mc_q;
   bsp_mc_ctrl_t  tx_mc_q;
   bsp_enables_t  rx_ena_q;
   bsp_enables_t  tx_ena_q;
   logic [15:0]   rdata_d;
   logic [15:0]   rdata_q;

   logic [3:0]    pins_s;
   logic          rx_clk_s;
   logic          tx_clk_s;
   logic          rx_data_s;
   logic          tx_data_s;
   logic          rx_clk_prev_q;
   logic          tx_clk_prev_q;
   logic          rx_clk_rise;
   logic          tx_clk_rise;

   bsp_clk_src_t  src;
   logic          src_tick;
   logic [7:0]    div_cnt_q;
   logic          gen_clk_q;

   logic [6:0]    rx_chan_q;
   logic [6:0]    tx_chan_q;
   logic          rx_gate;
   logic          tx_gate;
   logic          rx_on_q;
   logic          tx_on_q;

   // enable windows span eight words; writes and reads share this decode
   function automatic logic in_window(input logic [5:0] addr, input logic [5:0] base);
      return addr[5:3] == base[5:3];
   endfunction

   // stored control fields; the current-block bits are status only
   function automatic bsp_mc_ctrl_t mc_fields(input logic [15:0] w);
      return bsp_mc_ctrl_t'({w[`BSP_MC_WIDE:`BSP_MC_LOWER_LSB], w[`BSP_MC_SEL_MSB:0]});
   endfunction

   // control word as read back, with the live block of the channel counter
   function automatic logic [15:0] mc_word(input bsp_mc_ctrl_t mc, input logic [6:0] chan);
      logic [15:0] w;
      w = 16'h0000;
      w[`BSP_MC_WIDE:`BSP_MC_LOWER_LSB]  = mc[6:2];
      w[`BSP_MC_CUR_MSB:`BSP_MC_CUR_LSB] = chan[6:4];
      w[`BSP_MC_SEL_MSB:0]               = mc.multichannel_select;
      return w;
   endfunction

   // register writes
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pin_q <= bsp_pin_ctrl_t'(`BSP_REG_RESET);
      end else if (reg_write && reg_addr == `BSP_OFS_PIN_CTRL) begin
         // status and reserved bits are not writable
         pin_q <= bsp_pin_ctrl_t'(reg_wdata & `BSP_PIN_WR_MASK);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         clk_mode_q <= 1'b0;
         div_q      <= 8'h00;
      end else if (reg_write && reg_addr == `BSP_OFS_RATE_CFG_TWO) begin
         clk_mode_q <= reg_wdata[`BSP_CFG2_CLK_MODE];
         div_q      <= reg_wdata[`BSP_CFG2_DIV_MSB:0];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_mc_q <= '0;
         tx_mc_q <= '0;
      end else if (reg_write) begin
         if (reg_addr == `BSP_OFS_RX_MC_CTRL) begin
            rx_mc_q <= mc_fields(reg_wdata);
         end
         if (reg_addr == `BSP_OFS_TX_MC_CTRL) begin
            tx_mc_q <= mc_fields(reg_wdata);
         end
      end
   end

   // enable registers, one per partition and direction
   genvar p;
   generate
      for (p = 0; p < 8; p++) begin : g_ena
         always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
               rx_ena_q[p] <= `BSP_REG_RESET;
               tx_ena_q[p] <= `BSP_REG_RESET;
            end else if (reg_write) begin
               if (in_window(reg_addr, `BSP_OFS_RX_ENA_BASE) && reg_addr[2:0] == 3'(p)) begin
                  rx_ena_q[p] <= reg_wdata;
               end
               if (in_window(reg_addr, `BSP_OFS_TX_ENA_BASE) && reg_addr[2:0] == 3'(p)) begin
                  tx_ena_q[p] <= reg_wdata;
               end
            end
         end
      end
   endgenerate

   // register reads, data the cycle after the strobe
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_addr == `BSP_OFS_PIN_CTRL) begin
         rdata_d = pin_q;
         rdata_d[15:14] = 2'b00;
         // no sample clock pin exists, so its state reads low
         rdata_d[`BSP_PIN_SCLK_STATE]    = 1'b0;
         rdata_d[`BSP_PIN_TX_DATA_STATE] = tx_data_s;
         rdata_d[`BSP_PIN_RX_DATA_STATE] = rx_data_s;
      end else if (reg_addr == `BSP_OFS_RATE_CFG_TWO) begin
         rdata_d[`BSP_CFG2_CLK_MODE]  = clk_mode_q;
         rdata_d[`BSP_CFG2_DIV_MSB:0] = div_q;
      end else if (reg_addr == `BSP_OFS_RX_MC_CTRL) begin
         rdata_d = mc_word(rx_mc_q, rx_chan_q);
      end else if (reg_addr == `BSP_OFS_TX_MC_CTRL) begin
         rdata_d = mc_word(tx_mc_q, tx_chan_q);
      end else if (in_window(reg_addr, `BSP_OFS_RX_ENA_BASE)) begin
         rdata_d = rx_ena_q[reg_addr[2:0]];
      end else if (in_window(reg_addr, `BSP_OFS_TX_ENA_BASE)) begin
         rdata_d = tx_ena_q[reg_addr[2:0]];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 16'h0000;
      end else begin
         // zero between replies, so a stale word is never taken for one
         rdata_q <= reg_read ? rdata_d : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;

   // pin sampling
   bsp_sync2 #(
      .WIDTH (4)
   ) u_pin_sync (
      .core_clk (core_clk),
      .reset    (reset),
      .async_in ({rx_clock_pin_in, tx_clock_pin_in, rx_data_pin_in, tx_data_pin_in}),
      .sync_out (pins_s)
   );

   assign rx_clk_s  = pins_s[3];
   assign tx_clk_s  = pins_s[2];
   assign rx_data_s = pins_s[1];
   assign tx_data_s = pins_s[0];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_clk_prev_q <= 1'b0;
         tx_clk_prev_q <= 1'b0;
      end else begin
         rx_clk_prev_q <= rx_clk_s;
         tx_clk_prev_q <= tx_clk_s;
      end
   end

   // edge flops reset low, so a pin held low through reset shows no edge
   assign rx_clk_rise = rx_clk_s & ~rx_clk_prev_q;
   assign tx_clk_rise = tx_clk_s & ~tx_clk_prev_q;

   // generator source: a tick per source edge, clock mux avoided
   assign src = bsp_clk_src_t'({pin_q.sample_clock_pin_select, clk_mode_q});

   always_comb begin
      unique case (src)
         BSP_SRC_EXT_SAMPLE: src_tick = 1'b0;
         BSP_SRC_CPU:        src_tick = 1'b1;
         BSP_SRC_RX_PIN:     src_tick = rx_clk_rise;
         BSP_SRC_TX_PIN:     src_tick = tx_clk_rise;
      endcase
   end

   // divide by div+1 ticks per half period
   // the cpu source ticks every cycle, a pin source once per pin rise
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         div_cnt_q <= 8'h00;
         gen_clk_q <= 1'b0;
      end else if (src_tick) begin
         if (div_cnt_q >= div_q) begin
            div_cnt_q <= 8'h00;
            gen_clk_q <= ~gen_clk_q;
         end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
         end
      end
   end

   assign gen_clk = gen_clk_q;

   // bit clocks: generator when driven, synced pin otherwise
   assign rx_bit_clk = pin_q.rx_clock_direction ? gen_clk_q : rx_clk_s ^ pin_q.rx_clock_polarity;
   assign tx_bit_clk = pin_q.tx_clock_direction ? gen_clk_q : tx_clk_s ^ pin_q.tx_clock_polarity;

   // a clock pin feeding the generator must never also drive
   assign rx_clock_pin_oe  = pin_q.rx_clock_direction && src != BSP_SRC_RX_PIN;
   assign tx_clock_pin_oe  = pin_q.tx_clock_direction && src != BSP_SRC_TX_PIN;
   assign rx_clock_pin_out = gen_clk_q ^ pin_q.rx_clock_polarity;
   assign tx_clock_pin_out = gen_clk_q ^ pin_q.tx_clock_polarity;

   // frame sync pins
   assign rx_sync_pin_oe  = pin_q.rx_sync_direction & ~pin_q.rx_pins_as_io;
   assign tx_sync_pin_oe  = pin_q.tx_sync_direction & ~pin_q.tx_pins_as_io;
   assign rx_sync_pin_out = rx_sync_gen ^ pin_q.rx_sync_polarity;
   assign tx_sync_pin_out = tx_sync_gen ^ pin_q.tx_sync_polarity;

   // channel position within the TDM frame, saturating at the last channel
   // saturation stops an overlong frame from wrapping onto channel 0
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_chan_q <= 7'h00;
      end else if (rx_frame_start) begin
         rx_chan_q <= 7'h00;
      end else if (rx_word_end && rx_chan_q != `BSP_CHAN_LAST) begin
         rx_chan_q <= rx_chan_q + 7'h01;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         tx_chan_q <= 7'h00;
      end else if (tx_frame_start) begin
         tx_chan_q <= 7'h00;
      end else if (tx_word_end && tx_chan_q != `BSP_CHAN_LAST) begin
         tx_chan_q <= tx_chan_q + 7'h01;
      end
   end

   bsp_chan_gate u_rx_gate (
      .chan_index (rx_chan_q),
      .mc_ctrl    (rx_mc_q),
      .enables    (rx_ena_q),
      .chan_on    (rx_gate)
   );

   bsp_chan_gate u_tx_gate (
      .chan_index (tx_chan_q),
      .mc_ctrl    (tx_mc_q),
      .enables    (tx_ena_q),
      .chan_on    (tx_gate)
   );

   // registered so the shifters see a clean level per word
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_on_q <= 1'b0;
         tx_on_q <= 1'b0;
      end else begin
         rx_on_q <= rx_gate;
         tx_on_q <= tx_gate;
      end
   end

   assign rx_chan_enabled = rx_on_q;
   assign tx_chan_enabled = tx_on_q;

endmodule // bsp_clk_chan_sel
`default_nettype wire

// File: bsp_clk_chan_sel_monitor.sv
/*
   concurrent checks on register replies, clock pin drivers and channel gating.
   assumes it is bound into bsp_clk_chan_sel and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module bsp_clk_chan_sel_monitor (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // register port
   input  wire logic [5:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [15:0] reg_rdata,
   // clock outputs and the rx channel enable
   input  wire logic        rx_clock_pin_oe,
   input  wire logic        tx_clock_pin_oe,
   input  wire logic        tx_bit_clk,
   input  wire logic        tx_clock_pin_out,
   input  wire logic        rx_bit_clk,
   input  wire logic        gen_clk,
   input  wire logic        rx_chan_enabled
);
   // writable image of the four control words; status bits left out
   localparam logic [15:0] MASK [4] = '{16'h3f8f, 16'h20ff, 16'h03e3, 16'h03e3};
   logic [15:0] shd_q [4];
   logic        rx_sel_pin;
   logic        tx_sel_pin;
   logic        src_ext;
   logic        rx_all;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shd_q <= '{default: 16'h0000};
      end else if (reg_write && reg_addr < 6'h04) begin
         shd_q[reg_addr[1:0]] <= reg_wdata & MASK[reg_addr[1:0]];
      end
   end

   assign rx_sel_pin = shd_q[0][7] && !shd_q[1][13];
   assign tx_sel_pin = shd_q[0][7] && shd_q[1][13];
   assign src_ext    = !shd_q[0][7] && !shd_q[1][13];
   assign rx_all     = shd_q[2][1:0] == 2'b00;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // a read was taken on the previous edge
   sequence s_rd(logic [5:0] a);
      $past(reg_read) && $past(reg_addr) == a;
   endsequence

   sequence s_ext_held;
      src_ext [*2];
   endsequence

   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside a reply");
   pin_image_a: assert property (s_rd(6'h00) |-> (reg_rdata & 16'hff8f) == shd_q[0])
      else $error("pin control readback wrong");
   cfg_image_a: assert property (s_rd(6'h01) |-> reg_rdata == shd_q[1])
      else $error("rate config readback wrong");
   txmc_image_a: assert property (s_rd(6'h03) |-> (reg_rdata & 16'hffe3) == shd_q[3])
      else $error("tx multichannel readback wrong");
   unmapped_zero_a: assert property ($past(reg_read) &&
      $past(reg_addr) inside {[6'h04:6'h0f], [6'h20:6'h3f]} |-> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   rx_drv_off_a: assert property (rx_clock_pin_oe == (shd_q[0][8] && !rx_sel_pin))
      else $error("rx clock driver state wrong");
   tx_drv_off_a: assert property (tx_clock_pin_oe == (shd_q[0][9] && !tx_sel_pin))
      else $error("tx clock driver state wrong");
   tx_bitclk_a: assert property (shd_q[0][9] |-> tx_bit_clk == gen_clk)
      else $error("tx bit clock not from generator");
   gen_frozen_a: assert property (s_ext_held |=> $stable(gen_clk))
      else $error("generator moved on missing source");
   all_chan_a: assert property (rx_all [*3] |-> rx_chan_enabled)
      else $error("channel off with selection disabled");
   rx_bitclk_a: assert property (shd_q[0][8] |-> rx_bit_clk == gen_clk)
      else $error("rx bit clock not from generator");
   tx_pin_drive_a: assert property (tx_clock_pin_oe |-> tx_clock_pin_out == (gen_clk ^ shd_q[0][1]))
      else $error("tx clock pin not showing generator");
endmodule // bsp_clk_chan_sel_monitor

bind bsp_clk_chan_sel bsp_clk_chan_sel_monitor mon_inst (
   .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .rx_clock_pin_oe(rx_clock_pin_oe), .tx_clock_pin_oe(tx_clock_pin_oe),
   .tx_bit_clk(tx_bit_clk), .gen_clk(gen_clk), .rx_chan_enabled(rx_chan_enabled),
   .tx_clock_pin_out(tx_clock_pin_out), .rx_bit_clk(rx_bit_clk)
);
`default_nettype wire

// File: bsp_codec_model.sv
/*
   far-side serial device: link clock on both clock pins, data pin levels.
   assumes the device drives a clock pin only while its enable is high.
*/
`timescale 1ns/100ps
`default_nettype none
module bsp_codec_model (
   // bench control
   input  wire logic run,
   input  wire logic lvl,
   // device clock drivers
   input  wire logic rx_oe,
   input  wire logic rx_out,
   input  wire logic tx_oe,
   input  wire logic tx_out,
   // resolved pin levels
   output logic      rx_clk,
   output logic      tx_clk,
   output logic      rx_data,
   output logic      tx_data
);
   logic link_q = 1'b0;

   // 800 ns link clock, stands still while run is low
   always #400 if (run) link_q = ~link_q;

   // a pin the device drives shows the device, else the codec
   assign rx_clk  = rx_oe ? rx_out : link_q;
   assign tx_clk  = tx_oe ? tx_out : link_q;
   assign rx_data = lvl;
   assign tx_data = lvl;
endmodule // bsp_codec_model
`default_nettype wire

// File: bsp_clk_chan_sel_tb.sv
/*
   self-checking bench: registers, generator source selection, channel gating.
   assumes bsp_codec_model on the clock and data pins.
*/
`timescale 1ns/100ps
`default_nettype none
module bsp_clk_chan_sel_tb;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [5:0]  reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_write = 1'b0, reg_read = 1'b0;
   logic [15:0] reg_rdata, got, exq;
   logic        rx_clock_pin_in, rx_clock_pin_out, rx_clock_pin_oe;
   logic        tx_clock_pin_in, tx_clock_pin_out, tx_clock_pin_oe;
   logic        rx_data_pin_in, tx_data_pin_in, gen_clk, prev;
   logic        rx_chan_enabled, tx_chan_enabled;
   logic        fs = 1'b0, we = 1'b0, lvl = 1'b0, link_run = 1'b0;
   int          fails = 0, n_tests = 0, cnt;
   int          chs [9] = '{0, 1, 2, 16, 31, 32, 112, 127, 128};
   logic [8:0]  ex_rx = 9'b000010101, ex_tx = 9'b110100010;
   logic [5:0]  ca [8] = '{6'h02, 6'h10, 6'h11, 6'h12, 6'h03, 6'h18, 6'h1a, 6'h1f};
   logic [15:0] cd [8] = '{16'h0001, 16'h0005, 16'h8000, 16'hffff,
                           16'h0201, 16'h0002, 16'h0001, 16'h8000};

   always #50 core_clk = ~core_clk;

   bsp_clk_chan_sel bsp_clk_chan_sel_inst (
      .core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .rx_clock_pin_in, .rx_clock_pin_out, .rx_clock_pin_oe,
      .tx_clock_pin_in, .tx_clock_pin_out, .tx_clock_pin_oe,
      .rx_sync_pin_in(1'b0), .rx_sync_pin_out(), .rx_sync_pin_oe(),
      .tx_sync_pin_in(1'b0), .tx_sync_pin_out(), .tx_sync_pin_oe(),
      .rx_data_pin_in, .tx_data_pin_in, .rx_sync_gen(1'b0), .tx_sync_gen(1'b0),
      .rx_bit_clk(), .tx_bit_clk(), .gen_clk,
      .rx_frame_start(fs), .rx_word_end(we), .tx_frame_start(fs), .tx_word_end(we),
      .rx_chan_enabled, .tx_chan_enabled
   );

   bsp_codec_model bsp_codec_model_inst (
      .run(link_run), .lvl, .rx_oe(rx_clock_pin_oe), .rx_out(rx_clock_pin_out),
      .tx_oe(tx_clock_pin_oe), .tx_out(tx_clock_pin_out), .rx_clk(rx_clock_pin_in),
      .tx_clk(tx_clock_pin_in), .rx_data(rx_data_pin_in), .tx_data(tx_data_pin_in)
   );

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask

   // reply stands only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   // restart the frame, step n words; saturation keeps 128 at the last channel
   task automatic step(input int n);
      @(posedge core_clk);
      fs <= 1'b1;
      @(posedge core_clk);
      fs <= 1'b0;
      repeat (n) begin
         @(posedge core_clk);
         we <= 1'b1;
      end
      @(posedge core_clk);
      we <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      fails++;
      conclude();
   end

   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      wr(6'h3f, 16'hffff);
      for (int a = 0; a < 64; a++) begin
         rd(6'(a), 16'h0000);
      end
      lvl <= 1'b1;
      wr(6'h00, 16'hffff);
      rd(6'h00, 16'h3fbf);
      wr(6'h01, 16'hffff);
      rd(6'h01, 16'h20ff);
      wr(6'h03, 16'hffff);
      rd(6'h03, 16'h03e3);
      lvl <= 1'b0;
      link_run <= 1'b1;
      // both clock directions out, all four generator sources in turn
      for (int k = 0; k < 4; k++) begin
         wr(6'h00, {8'h03, k[1], 7'h00});
         wr(6'h01, {2'b00, k[0], 13'h0000});
         repeat (10) @(posedge core_clk);
         #1;
         cnt = 0;
         prev = gen_clk;
         repeat (100) begin
            @(posedge core_clk);
            #1;
            if (gen_clk !== prev) cnt++;
            prev = gen_clk;
         end
         got = {13'h0, rx_clock_pin_oe, tx_clock_pin_oe, 1'(cnt != 0)};
         exq = {13'h0, 1'(k != 2), 1'(k != 3), 1'(k != 0)};
         chk(got, exq);
         if (k == 1) chk(16'(cnt), 16'h0064);
      end
      link_run <= 1'b0;
      // rx narrow with C loaded but unused, tx wide
      for (int i = 0; i < 8; i++) begin
         wr(ca[i], cd[i]);
      end
      for (int i = 0; i < 9; i++) begin
         step(chs[i]);
         got = {14'h0, rx_chan_enabled, tx_chan_enabled};
         exq = {14'h0, ex_rx[i], ex_tx[i]};
         chk(got, exq);
      end
      rd(6'h03, 16'h021d);
      wr(6'h02, 16'h0201);
      step(32);
      got = {14'h0, rx_chan_enabled, tx_chan_enabled};
      chk(got, 16'h0003);
      conclude();
   end
endmodule // bsp_clk_chan_sel_tb
`default_nettype wire
